// file: hw/cefb_change_det.v
`timescale 1ns/1ns
// detects changes and rising bits of a status vector, optionally synchronising it first
module cefb_change_det #(
   parameter W = 1,
   parameter SYNC = 0
) (
   input wire i_clk,
   input wire i_reset_n,
   input wire [W-1:0] i_status,
   output wire o_change,
   output wire [W-1:0] o_rise
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   reg [W-1:0] held_q;
   reg [W-1:0] prev_q;
   // a synchronised level is valid only once the three stages and the hold stage have filled
   localparam [2:0] ARM_EDGES = (SYNC != 0) ? 3'h5 : 3'h1;
   reg [2:0] arm_cnt_q;
   wire armed;
   wire [W-1:0] value;

   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
         s3_q <= {W{1'b0}};
         held_q <= {W{1'b0}};
      end else begin
         s1_q <= i_status;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // a pin level counts only once the last two stages agree
         if (s2_q == s3_q) begin
            held_q <= s3_q;
         end
      end
   end

   assign value = (SYNC != 0) ? held_q : i_status;

   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         prev_q <= {W{1'b0}};
         arm_cnt_q <= 3'h0;
      end else begin
         prev_q <= value;
         if (arm_cnt_q != ARM_EDGES) begin
            arm_cnt_q <= arm_cnt_q + 3'h1;
         end
      end
   end

   // the samples before arming are a baseline, not events
   assign armed = (arm_cnt_q == ARM_EDGES);
   assign o_change = armed & (value != prev_q);
   assign o_rise = {W{armed}} & value & ~prev_q;
endmodule

// file: hw/cefb_defs.vh
`ifndef CEFB_DEFS_VH
`define CEFB_DEFS_VH

// register offsets
`define CEFB_ADDR_FLAGS_A 8'h25
`define CEFB_ADDR_FLAGS_B 8'h26
`define CEFB_ADDR_FAULT_FLAGS 8'h27
`define CEFB_ADDR_MASKS_A 8'h28
`define CEFB_ADDR_MASKS_B 8'h29
`define CEFB_ADDR_FAULT_MASKS 8'h2a

// reset values
`define CEFB_RST_FLAGS 8'h00
`define CEFB_RST_MASKS 8'h00

// implemented bits of each register; other bits read 0
`define CEFB_DEF_FLAGS_A 8'h03
`define CEFB_DEF_FLAGS_B 8'h9b
`define CEFB_DEF_FAULT_FLAGS 8'hfe
`define CEFB_DEF_MASKS_A 8'h03
`define CEFB_DEF_MASKS_B 8'h9b
`define CEFB_DEF_FAULT_MASKS 8'hfe

// bit positions, charger flags a
`define CEFB_BIT_CHARGE_PHASE 0
`define CEFB_BIT_CV_TIMER 1
// bit positions, charger flags b
`define CEFB_BIT_POWER_POINT 0
`define CEFB_BIT_SWITCH_SYNC 1
`define CEFB_BIT_REVERSE 3
`define CEFB_BIT_THERMISTOR 4
`define CEFB_BIT_INPUT_GOOD 7
// bit positions, fault flags
`define CEFB_BIT_DRV_SUPPLY 1
`define CEFB_BIT_SAFETY_TIMER 2
`define CEFB_BIT_THERMAL_SHUT 3
`define CEFB_BIT_BAT_OVERVOLT 4
`define CEFB_BIT_BAT_OVERCUR 5
`define CEFB_BIT_IN_OVERVOLT 6
`define CEFB_BIT_IN_UNDERVOLT 7

// interrupt pulse length in clock cycles
`define CEFB_INT_PULSE_CYCLES 1

`endif

// file: hw/cefb_event_flag_bank.v
`timescale 1ns/1ns
`include "cefb_defs.vh"
module cefb_event_flag_bank #(
   parameter INT_PULSE_CYCLES = `CEFB_INT_PULSE_CYCLES
) (
   input wire i_clk,
   input wire i_reset_n,
   // register access port from the serial management engine
   input wire [7:0] i_reg_addr,
   input wire i_reg_rd,
   input wire i_reg_wr,
   input wire [7:0] i_reg_wdata,
   output reg [7:0] o_reg_rdata,
   output reg o_reg_rvalid,
   // status from the charger core, same clock
   input wire [2:0] i_charge_phase,
   input wire i_cv_timer_expired,
   input wire [2:0] i_thermistor_zone_state,
   input wire i_reverse_mode,
   input wire [1:0] i_switching_sync_input,
   input wire [1:0] i_power_point_state,
   input wire i_safety_timer_expired,
   // status from analog detectors, asynchronous
   input wire i_input_power_good,
   input wire i_input_undervolt,
   input wire i_input_overvolt,
   input wire i_battery_overcurrent,
   input wire i_battery_overvolt,
   input wire i_thermal_shutdown,
   input wire i_gate_driver_supply_pin,
   // interrupt pulse, active high
   output reg o_int_pulse
);
   localparam CW = 16;

   // event strobes, one cycle each
   wire phase_change;
   wire [0:0] cv_rise;
   wire zone_change;
   wire rev_change;
   wire sync_change;
   wire pp_change;
   wire [0:0] safety_rise;
   wire pg_change;
   wire [5:0] fault_rise;
   wire [7:0] set_a;
   wire [7:0] set_b;
   wire [7:0] set_f;
   wire [7:0] flags_a;
   wire [7:0] flags_b;
   wire [7:0] flags_f;
   wire rd_a;
   wire rd_b;
   wire rd_f;
   wire [5:0] fault_level;
   // mask write strobes
   wire wr_mask_a;
   wire wr_mask_b;
   wire wr_mask_f;
   wire [7:0] int_src_a;
   wire [7:0] int_src_b;
   wire [7:0] int_src_f;
   wire int_event;
   wire pulse_busy;
   reg [7:0] mask_a_q;
   reg [7:0] mask_b_q;
   reg [7:0] mask_f_q;
   reg [7:0] rdata_d;
   reg [CW-1:0] pulse_cnt_q;
   // index of the per-bit fault detectors
   genvar gi;

   function hit;
      input [7:0] addr;
      input [7:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   // drops the bits that a register does not implement
   function [7:0] keep;
      input [7:0] raw;
      input [7:0] defined;
      begin
         keep = raw & defined;
      end
   endfunction

   // charger core status, already on this clock
   cefb_change_det #(.W(3), .SYNC(0)) u_phase (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_status(i_charge_phase),
      .o_change(phase_change),
      .o_rise()
   );

   cefb_change_det #(.W(1), .SYNC(0)) u_cv (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_status(i_cv_timer_expired),
      .o_change(),
      .o_rise(cv_rise)
   );

   cefb_change_det #(.W(3), .SYNC(0)) u_zone (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_status(i_thermistor_zone_state),
      .o_change(zone_change),
      .o_rise()
   );

   cefb_change_det #(.W(1), .SYNC(0)) u_rev (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_status(i_reverse_mode),
      .o_change(rev_change),
      .o_rise()
   );

   cefb_change_det #(.W(2), .SYNC(0)) u_sync (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_status(i_switching_sync_input),
      .o_change(sync_change),
      .o_rise()
   );

   cefb_change_det #(.W(2), .SYNC(0)) u_pp (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_status(i_power_point_state),
      .o_change(pp_change),
      .o_rise()
   );

   cefb_change_det #(.W(1), .SYNC(0)) u_safety (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_status(i_safety_timer_expired),
      .o_change(),
      .o_rise(safety_rise)
   );

   // detector levels arrive from outside the clock domain
   cefb_change_det #(.W(1), .SYNC(1)) u_pg (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_status(i_input_power_good),
      .o_change(pg_change),
      .o_rise()
   );

   // each fault level gets its own synchroniser, in fault register bit order
   assign fault_level = {i_input_undervolt, i_input_overvolt, i_battery_overcurrent,
                         i_battery_overvolt, i_thermal_shutdown, i_gate_driver_supply_pin};

   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_fault
         cefb_change_det #(.W(1), .SYNC(1)) u_det (
            .i_clk(i_clk),
            .i_reset_n(i_reset_n),
            .i_status(fault_level[gi]),
            .o_change(),
            .o_rise(fault_rise[gi])
         );
      end
   endgenerate

   // event vectors in register bit order
   assign set_a[7:2] = 6'h00;
   assign set_a[`CEFB_BIT_CV_TIMER] = cv_rise[0];
   assign set_a[`CEFB_BIT_CHARGE_PHASE] = phase_change;

   assign set_b[`CEFB_BIT_INPUT_GOOD] = pg_change;
   assign set_b[6:5] = 2'h0;
   assign set_b[`CEFB_BIT_THERMISTOR] = zone_change;
   assign set_b[`CEFB_BIT_REVERSE] = rev_change;
   assign set_b[2] = 1'b0;
   assign set_b[`CEFB_BIT_SWITCH_SYNC] = sync_change;
   assign set_b[`CEFB_BIT_POWER_POINT] = pp_change;

   assign set_f[`CEFB_BIT_IN_UNDERVOLT] = fault_rise[5];
   assign set_f[`CEFB_BIT_IN_OVERVOLT] = fault_rise[4];
   assign set_f[`CEFB_BIT_BAT_OVERCUR] = fault_rise[3];
   assign set_f[`CEFB_BIT_BAT_OVERVOLT] = fault_rise[2];
   assign set_f[`CEFB_BIT_THERMAL_SHUT] = fault_rise[1];
   assign set_f[`CEFB_BIT_SAFETY_TIMER] = safety_rise[0];
   assign set_f[`CEFB_BIT_DRV_SUPPLY] = fault_rise[0];
   assign set_f[0] = 1'b0;

   // a read of a flag register clears the flags it returns; reading a mask register clears nothing
   assign rd_a = i_reg_rd & hit(i_reg_addr, `CEFB_ADDR_FLAGS_A);
   assign rd_b = i_reg_rd & hit(i_reg_addr, `CEFB_ADDR_FLAGS_B);
   assign rd_f = i_reg_rd & hit(i_reg_addr, `CEFB_ADDR_FAULT_FLAGS);

   cefb_flag_reg #(.DEFINED(`CEFB_DEF_FLAGS_A), .RESET_VALUE(`CEFB_RST_FLAGS)) u_flags_a (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_set(set_a),
      .i_clear(rd_a),
      .o_flags(flags_a)
   );

   cefb_flag_reg #(.DEFINED(`CEFB_DEF_FLAGS_B), .RESET_VALUE(`CEFB_RST_FLAGS)) u_flags_b (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_set(set_b),
      .i_clear(rd_b),
      .o_flags(flags_b)
   );

   cefb_flag_reg #(.DEFINED(`CEFB_DEF_FAULT_FLAGS), .RESET_VALUE(`CEFB_RST_FLAGS)) u_flags_f (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_set(set_f),
      .i_clear(rd_f),
      .o_flags(flags_f)
   );

   // mask registers; a mask only gates the pulse, the flag still sets
   assign wr_mask_a = i_reg_wr & hit(i_reg_addr, `CEFB_ADDR_MASKS_A);
   assign wr_mask_b = i_reg_wr & hit(i_reg_addr, `CEFB_ADDR_MASKS_B);
   assign wr_mask_f = i_reg_wr & hit(i_reg_addr, `CEFB_ADDR_FAULT_MASKS);

   // first charger mask
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mask_a_q <= `CEFB_RST_MASKS;
      end else if (wr_mask_a) begin
         mask_a_q <= keep(i_reg_wdata, `CEFB_DEF_MASKS_A);
      end
   end

   // second charger mask
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mask_b_q <= `CEFB_RST_MASKS;
      end else if (wr_mask_b) begin
         mask_b_q <= keep(i_reg_wdata, `CEFB_DEF_MASKS_B);
      end
   end

   // fault mask
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mask_f_q <= `CEFB_RST_MASKS;
      end else if (wr_mask_f) begin
         mask_f_q <= keep(i_reg_wdata, `CEFB_DEF_FAULT_MASKS);
      end
   end

   // read data shows the flags as they stood before the clear
   always @* begin
      case (i_reg_addr)
         `CEFB_ADDR_FLAGS_A: begin
            rdata_d = flags_a;
         end
         `CEFB_ADDR_FLAGS_B: begin
            rdata_d = flags_b;
         end
         `CEFB_ADDR_FAULT_FLAGS: begin
            rdata_d = flags_f;
         end
         `CEFB_ADDR_MASKS_A: begin
            rdata_d = mask_a_q;
         end
         `CEFB_ADDR_MASKS_B: begin
            rdata_d = mask_b_q;
         end
         `CEFB_ADDR_FAULT_MASKS: begin
            rdata_d = mask_f_q;
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
   end

   // the answer follows every read strobe by one edge
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
      end
   end

   // read data holds until the next read
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         o_reg_rdata <= rdata_d;
      end
   end

   // unmasked events start an interrupt pulse; a new event restarts it
   assign int_src_a = set_a & ~mask_a_q;
   assign int_src_b = set_b & ~mask_b_q;
   assign int_src_f = set_f & ~mask_f_q;
   assign int_event = (|int_src_a) | (|int_src_b) | (|int_src_f);
   assign pulse_busy = (pulse_cnt_q != {CW{1'b0}});

   // counts the cycles left after the first of a pulse
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pulse_cnt_q <= {CW{1'b0}};
      end else if (int_event) begin
         pulse_cnt_q <= INT_PULSE_CYCLES[CW-1:0] - 16'h0001;
      end else if (pulse_busy) begin
         pulse_cnt_q <= pulse_cnt_q - 16'h0001;
      end
   end

   // the pulse itself comes straight from a flop
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_int_pulse <= 1'b0;
      end else begin
         o_int_pulse <= int_event | pulse_busy;
      end
   end
endmodule

// file: hw/cefb_flag_reg.v
`timescale 1ns/1ns
// eight sticky event flags, cleared on read; a set in the clearing cycle wins
module cefb_flag_reg #(
   parameter [7:0] DEFINED = 8'hff,
   parameter [7:0] RESET_VALUE = 8'h00
) (
   input wire i_clk,
   input wire i_reset_n,
   input wire [7:0] i_set,
   input wire i_clear,
   output wire [7:0] o_flags
);
   reg [7:0] flags_q;
   wire [7:0] flags_d;

   assign flags_d = ((i_clear ? 8'h00 : flags_q) | i_set) & DEFINED;

   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         flags_q <= RESET_VALUE & DEFINED;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign o_flags = flags_q;
endmodule

// file: testbench/cefb_assertions.sv
`timescale 1ns/1ns
module cefb_assertions #(
   parameter INT_PULSE_CYCLES = 1
) (
   input wire i_clk,
   input wire i_reset_n,
   input wire [7:0] i_reg_addr,
   input wire i_reg_rd,
   input wire i_reg_wr,
   input wire [7:0] i_reg_wdata,
   input wire [7:0] o_reg_rdata,
   input wire o_reg_rvalid,
   input wire [2:0] i_charge_phase,
   input wire i_cv_timer_expired,
   input wire [2:0] i_thermistor_zone_state,
   input wire i_reverse_mode,
   input wire [1:0] i_switching_sync_input,
   input wire [1:0] i_power_point_state,
   input wire o_int_pulse
);
   reg [7:0] ma_q, mb_q, ra_q;
   reg [1:0] arm_q;
   // shadow masks and last read address; arm_q skips the baseline sample after reset
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ma_q <= 8'h00;
         mb_q <= 8'h00;
         ra_q <= 8'h00;
         arm_q <= 2'h0;
      end else begin
         if (arm_q != 2'h3)
            arm_q <= arm_q + 2'h1;
         if (i_reg_rd)
            ra_q <= i_reg_addr;
         if (i_reg_wr && i_reg_addr == 8'h28)
            ma_q <= i_reg_wdata;
         if (i_reg_wr && i_reg_addr == 8'h29)
            mb_q <= i_reg_wdata;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   chk_read_answered: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
   chk_answer_caused: assert property (o_reg_rvalid |-> $past(i_reg_rd)) else $error("stray answer");
   chk_b_reserved: assert property (o_reg_rvalid && ra_q == 8'h26 |-> (o_reg_rdata & 8'h64) == 8'h00)
      else $error("reserved bit set");
   chk_fault_reserved: assert property (o_reg_rvalid && ra_q == 8'h27 |-> !o_reg_rdata[0])
      else $error("reserved bit set");
   chk_phase_pulse: assert property (arm_q == 2'h3 && $changed(i_charge_phase) && !ma_q[0] |=> o_int_pulse)
      else $error("no pulse on phase change");
   chk_cv_pulse: assert property (arm_q == 2'h3 && $rose(i_cv_timer_expired) && !ma_q[1] |=> o_int_pulse)
      else $error("no pulse on timer expiry");
   chk_zone_pulse: assert property (arm_q == 2'h3 && $changed(i_thermistor_zone_state) && !mb_q[4]
      |=> o_int_pulse) else $error("no pulse on zone change");
   chk_mode_pulse: assert property (arm_q == 2'h3 && (($changed(i_reverse_mode) && !mb_q[3]) ||
      ($changed(i_switching_sync_input) && !mb_q[1]) || ($changed(i_power_point_state) && !mb_q[0]))
      |=> o_int_pulse) else $error("no pulse on mode change");
endmodule
bind cefb_event_flag_bank cefb_assertions #(.INT_PULSE_CYCLES(INT_PULSE_CYCLES)) u_chk (.i_clk(i_clk),
   .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr),
   .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
   .i_charge_phase(i_charge_phase), .i_cv_timer_expired(i_cv_timer_expired),
   .i_thermistor_zone_state(i_thermistor_zone_state), .i_reverse_mode(i_reverse_mode),
   .i_switching_sync_input(i_switching_sync_input), .i_power_point_state(i_power_point_state),
   .o_int_pulse(o_int_pulse));

// file: testbench/cefb_host_model.sv
`timescale 1ns/1ns
module cefb_host_model (
   input wire i_clk,
   input wire [7:0] i_reg_rdata,
   input wire i_reg_rvalid,
   output reg [7:0] o_reg_addr,
   output reg o_reg_rd,
   output reg o_reg_wr,
   output reg [7:0] o_reg_wdata
);
   initial begin
      o_reg_addr = 8'h00;
      o_reg_rd = 1'b0;
      o_reg_wr = 1'b0;
      o_reg_wdata = 8'h00;
   end
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge i_clk);
         o_reg_addr <= a;
         o_reg_wdata <= d;
         o_reg_wr <= 1'b1;
         @(posedge i_clk);
         o_reg_wr <= 1'b0;
      end
   endtask
   // one strobe per read; apart from a reset, reading is the only way the flags clear
   task rd(input [7:0] a, output [7:0] d, output ok);
      integer i;
      begin
         ok = 1'b0;
         d = 8'h00;
         @(posedge i_clk);
         o_reg_addr <= a;
         o_reg_rd <= 1'b1;
         for (i = 0; i < 4 && !ok; i = i + 1) begin
            @(posedge i_clk);
            o_reg_rd <= 1'b0;
            #1;
            if (i_reg_rvalid === 1'b1) begin
               ok = 1'b1;
               d = i_reg_rdata;
            end
         end
      end
   endtask
endmodule

// file: testbench/test_charger_event_flag_bank.sv
`timescale 1ns/1ns
module test_charger_event_flag_bank;
   reg i_clk, i_reset_n, cvt, rev, ok;
   reg [2:0] phase, zone;
   reg [1:0] sync, pp;
   reg [7:0] flt, got;
   wire [7:0] addr, wdata, rdata;
   wire rd, wr, rvalid, irq;
   integer fail_count, comparisons;
   cefb_event_flag_bank dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(addr), .i_reg_rd(rd),
      .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .i_charge_phase(phase), .i_cv_timer_expired(cvt), .i_thermistor_zone_state(zone),
      .i_reverse_mode(rev), .i_switching_sync_input(sync), .i_power_point_state(pp),
      .i_safety_timer_expired(flt[2]), .i_input_power_good(flt[0]), .i_input_undervolt(flt[7]),
      .i_input_overvolt(flt[6]), .i_battery_overcurrent(flt[5]), .i_battery_overvolt(flt[4]),
      .i_thermal_shutdown(flt[3]), .i_gate_driver_supply_pin(flt[1]), .o_int_pulse(irq));
   cefb_host_model host (.i_clk(i_clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid), .o_reg_addr(addr),
      .o_reg_rd(rd), .o_reg_wr(wr), .o_reg_wdata(wdata));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   task check(input [7:0] seen, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task close_out;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, fail_count);
         if (fail_count == 0 && comparisons > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task rdx(input [7:0] a, input [7:0] exp);
      begin
         host.rd(a, got, ok);
         if (ok !== 1'b1) begin
            fail_count = fail_count + 1;
            close_out;
         end else begin
            check(got, exp);
         end
      end
   endtask
   task irq_is(input exp);
      begin
         @(posedge i_clk);
         #1;
         check({7'h00, irq}, {7'h00, exp});
      end
   endtask
   // watches eight edges for any interrupt pulse
   task irq_seen(input exp);
      integer n;
      reg got_irq;
      begin
         got_irq = 1'b0;
         for (n = 0; n < 8; n = n + 1) begin
            @(posedge i_clk);
            #1;
            if (irq === 1'b1)
               got_irq = 1'b1;
         end
         check({7'h00, got_irq}, {7'h00, exp});
      end
   endtask
   task t_regs;
      integer a;
      begin
         for (a = 8'h25; a <= 8'h2a; a = a + 1)
            rdx(a[7:0], 8'h00);
         rdx(8'h30, 8'h00);
         host.wr(8'h26, 8'hff);
         rdx(8'h26, 8'h00);
         host.wr(8'h28, 8'hff);
         rdx(8'h28, 8'h03);
         rdx(8'h25, 8'h00);
         host.wr(8'h28, 8'h00);
      end
   endtask
   task t_phase;
      begin
         @(posedge i_clk);
         phase <= 3'h3;
         irq_is(1'b1);
         irq_is(1'b0);
         rdx(8'h25, 8'h01);
         rdx(8'h25, 8'h00);
         @(posedge i_clk);
         cvt <= 1'b1;
         irq_is(1'b1);
         rdx(8'h25, 8'h02);
         @(posedge i_clk);
         cvt <= 1'b0;
         irq_is(1'b0);
         rdx(8'h25, 8'h00);
         host.wr(8'h28, 8'h01);
         @(posedge i_clk);
         phase <= 3'h4;
         irq_is(1'b0);
         rdx(8'h25, 8'h01);
         host.wr(8'h28, 8'h00);
      end
   endtask
   task t_b;
      integer k;
      reg [7:0] exp [0:4];
      begin
         exp[0] = 8'h10;
         exp[1] = 8'h08;
         exp[2] = 8'h02;
         exp[3] = 8'h01;
         exp[4] = 8'h80;
         for (k = 0; k < 10; k = k + 1) begin
            if (k == 5)
               host.wr(8'h29, 8'h9b);
            @(posedge i_clk);
            case (k % 5)
               0: zone <= zone + 3'h1;
               1: rev <= ~rev;
               2: sync <= sync + 2'h1;
               3: pp <= pp + 2'h1;
               default: flt[0] <= ~flt[0];
            endcase
            irq_seen(k < 5);
            rdx(8'h26, exp[k % 5]);
         end
         host.wr(8'h29, 8'h00);
      end
   endtask
   task t_fault;
      integer b;
      begin
         for (b = 1; b < 8; b = b + 1) begin
            host.wr(8'h2a, b[0] ? 8'h00 : 8'hfe);
            @(posedge i_clk);
            flt[b] <= 1'b1;
            irq_seen(b[0]);
            rdx(8'h27, 8'h01 << b);
            @(posedge i_clk);
            flt[b] <= 1'b0;
            irq_seen(1'b0);
            rdx(8'h27, 8'h00);
         end
         host.wr(8'h2a, 8'h00);
      end
   endtask
   task t_race;
      begin
         fork
            host.rd(8'h25, got, ok);
            begin
               @(posedge i_clk);
               phase <= phase + 3'h1;
            end
         join
         check({7'h00, ok}, 8'h01);
         check(got, 8'h00);
         rdx(8'h25, 8'h01);
      end
   endtask
   task t_reset;
      begin
         host.wr(8'h28, 8'h03);
         @(posedge i_clk);
         phase <= phase + 3'h1;
         @(posedge i_clk);
         i_reset_n <= 1'b0;
         repeat (2) @(posedge i_clk);
         i_reset_n <= 1'b1;
         repeat (8) @(posedge i_clk);
         rdx(8'h28, 8'h00);
         rdx(8'h25, 8'h00);
         irq_is(1'b0);
      end
   endtask
   initial begin
      fail_count = 0;
      comparisons = 0;
      i_reset_n = 1'b0;
      phase = 3'h0;
      zone = 3'h0;
      cvt = 1'b0;
      rev = 1'b0;
      sync = 2'h0;
      pp = 2'h0;
      flt = 8'h00;
      repeat (20) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      t_regs;
      t_phase;
      t_b;
      t_fault;
      t_race;
      t_reset;
      t_regs;
      close_out;
   end
endmodule
